// ==== hdl/cwd_config_decode.v ====
// Configuration word fuse store, decoder, pin lock and write protect
//
// The register addresses and the strobed register port were decided locally.
`default_nettype none
`include "cwd_defines.vh"

module cwd_config_decode (
    input wire mclk,
    input wire resetn,
    input wire reload_req,
    input wire deep_sleep,
    input wire [3:0] addr,
    input wire [23:0] wdata,
    input wire wr,
    input wire rd,
    input wire [6:0] wp_page,
    output reg [23:0] rdata_r,
    output reg pin_map_lock_r,
    output reg [31:0] pin_sel_r,
    output reg bor_enable_r,
    output reg bor_cfg_invalid_r,
    output reg posc_enable_r,
    output reg [1:0] posc_mode_r,
    output reg [2:0] wdt_win_r,
    output reg pin_lock_once_r,
    output reg wp_protected_r
);

    // Unlock sequencer states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_KEY1 = 3'b010;
    localparam [2:0] ST_OPEN = 3'b100;

    reg [15:0] cw2_fuse_r;
    reg [15:0] cw3_fuse_r;
    reg cw2_done_r;
    reg cw3_done_r;
    reg [15:0] cw2_lat_r;
    reg [15:0] cw3_lat_r;
    reg load_pend_r;
    reg [2:0] st_r;
    reg [2:0] st_nxt;
    reg [7:0] pin_mem_r [0:3];
    reg [23:0] rd_nxt;
    reg prot_nxt;
    reg [2:0] win_nxt;
    wire once_en;
    wire wp_end;
    wire wp_dis;
    wire wp_cfgp;
    wire [6:0] wp_fp;
    wire cfg_page_prot;
    wire lock_wr;
    wire pin_wr;
    wire cw2_wr;
    wire cw3_wr;
    wire key_wr;
    integer i;

    // Extend a 16-bit fuse word to the 24-bit read view
    function [23:0] cwd_word_view;
        input [15:0] w;
        begin
            cwd_word_view = {`CWD_UPPER_ONES, w};
        end
    endfunction

    // Segment membership on 256-word pages, both bounds inclusive
    function cwd_in_segment;
        input [6:0] page;
        input end_sel;
        input [6:0] bound;
        begin
            if (end_sel)
                cwd_in_segment = (page >= bound);
            else
                cwd_in_segment = (page <= bound);
        end
    endfunction

    // Live fields come from the latched copy, never from the fuses
    assign once_en = cw2_lat_r[`CWD_CW2_ONCE];
    assign wp_end = cw3_lat_r[`CWD_CW3_END];
    assign wp_dis = cw3_lat_r[`CWD_CW3_DIS];
    assign wp_cfgp = cw3_lat_r[`CWD_CW3_CFGP];
    assign wp_fp = cw3_lat_r[`CWD_CW3_FP_HI:`CWD_CW3_FP_LO];
    assign lock_wr = wr && (addr == `CWD_OFS_LOCK);
    assign pin_wr = wr && (addr[3:2] == `CWD_OFS_PINSEL);
    assign cw2_wr = wr && (addr == `CWD_OFS_CW2);
    assign cw3_wr = wr && (addr == `CWD_OFS_CW3);
    assign key_wr = wr && (addr == `CWD_OFS_KEY);

    // Fuse words: all ones until programmed, then frozen until reset
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cw2_fuse_r <= `CWD_FUSE_RST;
            cw3_fuse_r <= `CWD_FUSE_RST;
            cw2_done_r <= 1'b0;
            cw3_done_r <= 1'b0;
        end
        else
        begin
            // Program once: later writes to a programmed word are ignored
            if (cw2_wr && !cw2_done_r)
            begin
                cw2_fuse_r <= wdata[15:0];
                cw2_done_r <= 1'b1;
            end
            if (cw3_wr && !cw3_done_r)
            begin
                cw3_fuse_r <= wdata[15:0];
                cw3_done_r <= 1'b1;
            end
        end
    end

    // Latch the fuses on the first edge after reset release or on reload
    // so that programming at run time cannot shift live settings
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            load_pend_r <= 1'b1;
            cw2_lat_r <= `CWD_FUSE_RST;
            cw3_lat_r <= `CWD_FUSE_RST;
        end
        else
        begin
            load_pend_r <= 1'b0;
            if (load_pend_r || reload_req)
            begin
                cw2_lat_r <= cw2_fuse_r;
                cw3_lat_r <= cw3_fuse_r;
            end
        end
    end

    // Unlock sequencer: two keys back to back open one lock write
    // Any other write in between cancels, so a stray store cannot unlock
    always @*
    begin
        st_nxt = ST_IDLE;
        case (st_r)
            ST_IDLE:
                if (key_wr && wdata == `CWD_KEY1)
                    st_nxt = ST_KEY1;
            ST_KEY1:
                if (key_wr && wdata == `CWD_KEY2)
                    st_nxt = ST_OPEN;
                else if (!wr)
                    st_nxt = ST_KEY1;
            ST_OPEN:
                if (!wr)
                    st_nxt = ST_OPEN;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // Pin lock and pin-select storage
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= ST_IDLE;
            pin_map_lock_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1)
                pin_mem_r[i] <= `CWD_PINSEL_RST;
        end
        else
        begin
            st_r <= st_nxt;
            // Only the write right after both keys may move the lock
            if (lock_wr && st_r == ST_OPEN)
            begin
                if (wdata[0])
                    pin_map_lock_r <= 1'b1;
                else if (!once_en)
                    pin_map_lock_r <= 1'b0;
            end
            // Locked mapping refuses writes; one-way mode never unlocks
            if (pin_wr && !pin_map_lock_r)
                pin_mem_r[addr[1:0]] <= wdata[7:0];
        end
    end

    // Config page guarded by end select, a boundary on that page or a clear CFGP bit, unless DIS is set
    assign cfg_page_prot = !wp_dis &&
        (wp_end || wp_fp == `CWD_LAST_PAGE || !wp_cfgp);

    // Segment check on 256-word page numbers
    always @*
    begin
        if (wp_page == `CWD_LAST_PAGE)
            prot_nxt = cfg_page_prot;
        else if (wp_dis)
            prot_nxt = 1'b0;
        else
            prot_nxt = cwd_in_segment(wp_page, wp_end, wp_fp);
    end

    // Watchdog window decode
    // Width kept in eighths so the watchdog compares without division
    always @*
    begin
        case (cw3_lat_r[`CWD_CW3_WIN_HI:`CWD_CW3_WIN_LO])
            2'h3: win_nxt = `CWD_WIN_25;
            2'h2: win_nxt = `CWD_WIN_375;
            2'h1: win_nxt = `CWD_WIN_50;
            default: win_nxt = `CWD_WIN_75;
        endcase
    end

    // Read mux; unmapped offsets read zero
    always @*
    begin
        rd_nxt = 24'h000000;
        if (addr == `CWD_OFS_CW2)
            rd_nxt = cwd_word_view(cw2_fuse_r);
        else if (addr == `CWD_OFS_CW3)
            rd_nxt = cwd_word_view(cw3_fuse_r);
        else if (addr == `CWD_OFS_LOCK)
            rd_nxt = {23'h0, pin_map_lock_r};
        else if (addr[3:2] == `CWD_OFS_PINSEL)
            rd_nxt = {16'h0000, pin_mem_r[addr[1:0]]};
    end

    // Read data stands for one cycle only; idle cycles return zero
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_r <= 24'h000000;
        else
            rdata_r <= rd ? rd_nxt : 24'h000000;
    end

    // Pin-select image trails the storage by one cycle
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pin_sel_r <= 32'h00000000;
        else
            pin_sel_r <= {pin_mem_r[3], pin_mem_r[2],
                          pin_mem_r[1], pin_mem_r[0]};
    end

    // Protect answer for wp_page; the lag keeps it a flop output
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            wp_protected_r <= 1'b0;
        else
            wp_protected_r <= prot_nxt;
    end

    // Decoded settings, all from the latched copy of the fuses
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            bor_enable_r <= 1'b0;
            bor_cfg_invalid_r <= 1'b0;
            posc_enable_r <= 1'b0;
            posc_mode_r <= `CWD_POSC_OFF;
            wdt_win_r <= `CWD_WIN_25;
            pin_lock_once_r <= 1'b1;
        end
        else
        begin
            // Mixed pairs are reserved; treated as off and flagged
            bor_enable_r <= cw3_lat_r[`CWD_CW3_BROWNOUT_ENABLE] &&
                cw2_lat_r[`CWD_CW2_BOROVR] && !deep_sleep;
            bor_cfg_invalid_r <= cw3_lat_r[`CWD_CW3_BROWNOUT_ENABLE] ^
                cw2_lat_r[`CWD_CW2_BOROVR];
            posc_mode_r <= cw2_lat_r[`CWD_CW2_POSC_HI:`CWD_CW2_POSC_LO];
            posc_enable_r <= cw2_lat_r[`CWD_CW2_POSC_HI:`CWD_CW2_POSC_LO]
                != `CWD_POSC_OFF;
            wdt_win_r <= win_nxt;
            pin_lock_once_r <= once_en;
        end
    end

endmodule // cwd_config_decode
`default_nettype wire

// ==== hdl/cwd_defines.vh ====
// Constants for the configuration word decoder: offsets, fields, resets
`ifndef CWD_DEFINES_VH
`define CWD_DEFINES_VH
// Register offsets on the plain register port
`define CWD_OFS_CW2 4'h0
`define CWD_OFS_CW3 4'h1
`define CWD_OFS_LOCK 4'h2
`define CWD_OFS_KEY 4'h3
`define CWD_OFS_PINSEL 2'h1
// Unlock key sequence, two back to back writes to the key register
`define CWD_KEY1 24'h000046
`define CWD_KEY2 24'h000057
// Unprogrammed fuse word, unimplemented upper byte and pin-select reset
`define CWD_FUSE_RST 16'hFFFF
`define CWD_UPPER_ONES 8'hFF
`define CWD_PINSEL_RST 8'h00
// Second word fields
`define CWD_CW2_ONCE 4
`define CWD_CW2_BOROVR 3
`define CWD_CW2_POSC_HI 1
`define CWD_CW2_POSC_LO 0
// Third word fields
`define CWD_CW3_END 15
`define CWD_CW3_CFGP 14
`define CWD_CW3_DIS 13
`define CWD_CW3_BROWNOUT_ENABLE 12
`define CWD_CW3_WIN_HI 11
`define CWD_CW3_WIN_LO 10
`define CWD_CW3_FP_HI 6
`define CWD_CW3_FP_LO 0
// Primary oscillator encodings
`define CWD_POSC_OFF 2'h3
`define CWD_POSC_HS 2'h2
`define CWD_POSC_XT 2'h1
`define CWD_POSC_EC 2'h0
// Watchdog window width in eighths of the timeout period
`define CWD_WIN_25 3'h2
`define CWD_WIN_375 3'h3
`define CWD_WIN_50 3'h4
`define CWD_WIN_75 3'h6
// Last implemented 256-word protection page, also the config word page
`define CWD_LAST_PAGE 7'h7F
`endif

// ==== sim/cwd_decode_monitor.sv ====
// Checker of the decoder outputs against the configuration rules
`default_nettype none
module cwd_decode_monitor (
    input wire mclk,
    input wire resetn,
    input wire reload_req,
    input wire deep_sleep,
    input wire [3:0] addr,
    input wire rd,
    input wire [23:0] rdata_r,
    input wire pin_map_lock_r,
    input wire [31:0] pin_sel_r,
    input wire bor_enable_r,
    input wire bor_cfg_invalid_r,
    input wire posc_enable_r,
    input wire [1:0] posc_mode_r,
    input wire [2:0] wdt_win_r,
    input wire pin_lock_once_r
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [1:0] up_r;
    // Settings are only settled a few edges after reset
    always @(posedge mclk or negedge resetn)
        if (!resetn) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // No reload seen lately, so nothing may re-latch
    sequence s_calm;
        !reload_req && !$past(reload_req) && !$past(reload_req, 2);
    endsequence
    property p_idle; !$past(rd) |-> rdata_r == 24'h000000; endproperty
    property p_upper;
        $past(rd) && $past(addr) < 4'h2 |-> rdata_r[23:16] == 8'hFF;
    endproperty
    property p_posc; posc_enable_r == (posc_mode_r != 2'h3); endproperty
    property p_win; wdt_win_r inside {3'h2, 3'h3, 3'h4, 3'h6}; endproperty
    property p_pair; !(bor_enable_r && bor_cfg_invalid_r); endproperty
    property p_sleep; $past(deep_sleep) |-> !bor_enable_r; endproperty
    property p_hold;
        up_r == 2'h3 ##0 s_calm |=> $stable({posc_mode_r, wdt_win_r,
            pin_lock_once_r, bor_cfg_invalid_r});
    endproperty
    property p_once;
        pin_lock_once_r && pin_map_lock_r ##0 s_calm |=> pin_map_lock_r;
    endproperty
    property p_frozen;
        pin_map_lock_r && $past(pin_map_lock_r) ##0 s_calm
            |=> $stable(pin_sel_r);
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data not idle");
    a_upper: assert property (p_upper)
        else $error("upper byte not ones");
    a_posc: assert property (p_posc)
        else $error("osc enable wrong");
    a_win: assert property (p_win)
        else $error("window code wrong");
    a_pair: assert property (p_pair)
        else $error("reserved pair on");
    a_sleep: assert property (p_sleep)
        else $error("brown-out in sleep");
    a_hold: assert property (p_hold)
        else $error("settings moved");
    a_once: assert property (p_once)
        else $error("lock cleared");
    a_frozen: assert property (p_frozen)
        else $error("pin select moved");
endmodule // cwd_decode_monitor
bind cwd_config_decode cwd_decode_monitor u_mon (.mclk(mclk),
    .resetn(resetn), .reload_req(reload_req), .deep_sleep(deep_sleep),
    .addr(addr), .rd(rd), .rdata_r(rdata_r),
    .pin_map_lock_r(pin_map_lock_r), .pin_sel_r(pin_sel_r),
    .bor_enable_r(bor_enable_r), .bor_cfg_invalid_r(bor_cfg_invalid_r),
    .posc_enable_r(posc_enable_r), .posc_mode_r(posc_mode_r),
    .wdt_win_r(wdt_win_r), .pin_lock_once_r(pin_lock_once_r));
`default_nettype wire

// ==== sim/cwd_config_decode_tb_top.sv ====
// Bench for the configuration word decoder
`default_nettype none
`include "cwd_defines.vh"
module cwd_config_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, resetn = 0, reload_req = 0, deep_sleep = 0;
    logic wr = 0, rd = 0;
    logic [3:0] addr = 4'h0;
    logic [23:0] wdata = 24'h000000;
    logic [6:0] wp_page = 7'h00;
    wire [23:0] rdata;
    wire [31:0] pin_sel;
    wire [1:0] posc_mode;
    wire [2:0] win;
    wire lock, bor_en, bor_inv, posc_en, once, wp_hit;
    int n_fail = 0, check_count = 0, cyc = 0;
    logic [15:0] cw2, cw3;
    logic [2:0] win_tab [4] = '{3'h6, 3'h4, 3'h3, 3'h2};
    cwd_config_decode DUT (.mclk(mclk), .resetn(resetn),
        .reload_req(reload_req), .deep_sleep(deep_sleep), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .wp_page(wp_page), .rdata_r(rdata),
        .pin_map_lock_r(lock), .pin_sel_r(pin_sel), .bor_enable_r(bor_en),
        .bor_cfg_invalid_r(bor_inv), .posc_enable_r(posc_en),
        .posc_mode_r(posc_mode), .wdt_win_r(win), .pin_lock_once_r(once),
        .wp_protected_r(wp_hit));
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One strobe cycle; read data is settled when the task returns
    task automatic bus(input logic w, input logic [3:0] a, input int d);
        @(posedge mclk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d[23:0];
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic unlock;
        bus(1, `CWD_OFS_KEY, `CWD_KEY1);
        bus(1, `CWD_OFS_KEY, `CWD_KEY2);
    endtask
    // Fuses only return to ones on reset, so each pattern needs one
    task automatic prog(input logic [15:0] a, input logic [15:0] b);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        bus(1, `CWD_OFS_CW2, a);
        bus(1, `CWD_OFS_CW3, b);
        @(posedge mclk);
        reload_req <= 1'b1;
        @(posedge mclk);
        reload_req <= 1'b0;
        settle();
    endtask
    function automatic logic wp_exp(input logic [6:0] p, input logic [15:0] c);
        if (c[13]) return 1'b0;
        if (p == `CWD_LAST_PAGE)
            return c[15] || !c[14] || c[6:0] == 7'h7F;
        return c[15] ? p >= c[6:0] : p <= c[6:0];
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        settle();
        chk({bor_en, bor_inv, posc_en, once, win}, 7'h4A);
        bus(0, `CWD_OFS_CW3, 0);
        chk(rdata, 24'hFFFFFF);
        bus(1, 4'hF, 24'h00FFFF);
        bus(0, 4'hF, 0);
        chk(rdata, 24'h000000);
        $display("reset test done");
        for (int i = 0; i < 5; i++)
        begin
            cw2 = {11'h7FF, i[0], i[0], 1'b1, i[1:0]};
            cw3 = {i[0], i[1], i[2], i[1], i[1:0], 3'h7, 7'h10};
            prog(cw2, cw3);
            bus(1, `CWD_OFS_CW2, 24'h000000);
            bus(0, `CWD_OFS_CW2, 0);
            chk(rdata, {8'hFF, cw2});
            chk({posc_en, posc_mode}, {i[1:0] != 2'h3, i[1:0]});
            chk(win, win_tab[i[1:0]]);
            chk({bor_en, bor_inv}, {i[1] & i[0], i[1] ^ i[0]});
            @(posedge mclk);
            deep_sleep <= 1'b1;
            settle();
            chk(bor_en, 1'b0);
            @(posedge mclk);
            deep_sleep <= 1'b0;
            settle();
            chk(bor_en, i[1] & i[0]);
            foreach (win_tab[k])
            begin
                @(posedge mclk);
                wp_page <= (k == 3) ? 7'h7F : 7'h10 * k;
                settle();
                chk(wp_hit, wp_exp(wp_page, cw3));
            end
            chk(once, i[0]);
            bus(1, 4'h4, 24'h0000A5);
            bus(1, `CWD_OFS_LOCK, 1);
            settle();
            chk({lock, pin_sel[7:0]}, 9'h0A5);
            unlock();
            bus(1, `CWD_OFS_LOCK, 1);
            bus(1, 4'h4, 24'h00005A);
            settle();
            chk({lock, pin_sel[7:0]}, 9'h1A5);
            unlock();
            bus(1, `CWD_OFS_LOCK, 0);
            settle();
            chk(lock, i[0]);
            bus(0, `CWD_OFS_LOCK, 0);
            chk(rdata, i[0]);
            bus(1, 4'h4, 24'h00005A);
            bus(0, 4'h4, 0);
            chk(rdata, i[0] ? 24'h0000A5 : 24'h00005A);
            $display("pattern %0d done", i);
        end
        end_of_test();
    end
endmodule // cwd_config_decode_tb_top
`default_nettype wire
